// ==== bench/srocfg_bank_test.sv ====
// Self-checking bench for the reference output configuration bank.
// Assumes the design header is on the include path and the checker is compiled.
`timescale 1ns/10ps

module srocfg_bank_test;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic bias_type = 1'b0;
  logic [7:0] chan_clk = 8'h00;
  logic sysref_in = 1'b1;
  wire [7:0] reg_rdata;
  wire reg_rvalid;
  wire [7:0] reference_output, out_bias, out_lvpecl, out_powered;
  wire [87:0] out_delay_ps;
  wire [15:0] out_amp;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [10:0] fine_tab [8] = '{11'h000, 11'h019, 11'h032, 11'h04B, 11'h055, 11'h06E, 11'h087, 11'h0A0};
  logic [7:0] dly_ofs [8] = '{8'h28, 8'h29, 8'h2A, 8'h38, 8'h39, 8'h48, 8'h49, 8'h58};

  srocfg_bank #(.NUM_OUT(8)) srocfg_bank_inst (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bias_type(bias_type), .chan_clk(chan_clk), .sysref_in(sysref_in), .reference_output(reference_output),
    .out_delay_ps(out_delay_ps), .out_bias(out_bias), .out_amp(out_amp), .out_lvpecl(out_lvpecl),
    .out_powered(out_powered));

  // Free-running 10 MHz clock.
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // Compares a seen value with an expected one and counts both outcomes.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe at a falling edge, then one idle cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    @(negedge sys_clk);
  endtask

  // One-cycle read strobe; the answer is checked while reg_rvalid stands.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    check({15'h0000, reg_rvalid}, 16'h0001);
    check({8'h00, reg_rdata}, {8'h00, exp});
    @(negedge sys_clk);
  endtask

  // Write immediately followed by a read of the same address.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    check({15'h0000, reg_rvalid}, 16'h0001);
    check({8'h00, reg_rdata}, {8'h00, exp});
    @(negedge sys_clk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end

  // Main sequence of tests.
  initial begin
    logic [7:0] d;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    rd(8'h28, 8'h10);
    rd(8'h2C, 8'h00);
    rd(8'h76, 8'h00);
    check({8'h00, out_powered}, 16'h00FF);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      d = {1'b0, i[1:0], 1'b1, i[2:0], i[2]};
      wr(dly_ofs[i], d);
      rd(dly_ofs[i], d);
    end
    for (int i = 0; i < 8; i++) begin
      d = {1'b0, i[1:0], 1'b1, i[2:0], i[2]};
      rd(dly_ofs[i], d);
      check({5'h00, out_delay_ps[i*11 +: 11]}, 16'(i * 203 + fine_tab[i]));
    end
    wr(8'h00, 8'hA5);
    rd(8'h00, 8'h00);
    wr_rd(8'h28, 8'hFF, 8'h7F);
    check({5'h00, out_delay_ps[10:0]}, 16'(7 * 203 + 160));
    $display("test delays done");
    for (int a = 0; a < 4; a++) begin
      wr(8'h2C, {3'h0, a[0], a[1:0], 2'h0});
      @(negedge sys_clk);
      check({14'h0000, out_amp[1:0]}, 16'(a));
      check({15'h0000, out_lvpecl[0]}, {15'h0000, a[0]});
    end
    wr(8'h2C, 8'h9C);
    @(negedge sys_clk);
    check({12'h000, out_powered[0], out_lvpecl[0], out_amp[1:0]}, 16'h0000);
    rd(8'h2C, 8'h9C);
    wr(8'h2C, 8'h20);
    @(negedge sys_clk);
    check({8'h00, out_bias}, 16'h0000);
    bias_type = 1'b1;
    @(negedge sys_clk);
    check({8'h00, out_bias}, 16'h0001);
    $display("test power done");
    wr(8'h76, 8'hFF);
    repeat (4) @(negedge sys_clk);
    check({8'h00, reference_output}, 16'h00FF);
    wr(8'h28, 8'h00);
    @(negedge sys_clk);
    check({8'h00, reference_output}, 16'h00FE);
    chan_clk = 8'h01;
    repeat (4) @(negedge sys_clk);
    check({8'h00, reference_output}, 16'h00FF);
    wr(8'h2C, 8'h80);
    @(negedge sys_clk);
    check({8'h00, reference_output}, 16'h00FE);
    wr(8'h76, 8'h01);
    @(negedge sys_clk);
    check({8'h00, reference_output}, 16'h0080);
    sysref_in = 1'b0;
    repeat (4) @(negedge sys_clk);
    check({8'h00, reference_output}, 16'h0000);
    $display("test routing done");
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    rd(8'h28, 8'h10);
    check({reference_output, out_powered}, 16'h00FF);
    $display("test reset done");
    final_report();
  end
endmodule

bind srocfg_bank srocfg_chk #(.NUM_OUT(NUM_OUT)) srocfg_chk_inst (.sys_clk(sys_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .bias_type(bias_type), .chan_clk(chan_clk), .sysref_in(sysref_in),
  .reference_output(reference_output), .out_delay_ps(out_delay_ps), .out_bias(out_bias), .out_amp(out_amp),
  .out_lvpecl(out_lvpecl), .out_powered(out_powered));

// ==== bench/srocfg_chk.sv ====
// Concurrent checks on the ports of the reference output configuration bank.
// Assumes it is bound to srocfg_bank and shares its single clock and reset.
`timescale 1ns/10ps

module srocfg_chk #(
  parameter NUM_OUT = 8
) (
  input wire sys_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire bias_type,
  input wire [NUM_OUT-1:0] chan_clk,
  input wire sysref_in,
  input wire [NUM_OUT-1:0] reference_output,
  input wire [NUM_OUT*11-1:0] out_delay_ps,
  input wire [NUM_OUT-1:0] out_bias,
  input wire [NUM_OUT*2-1:0] out_amp,
  input wire [NUM_OUT-1:0] out_lvpecl,
  input wire [NUM_OUT-1:0] out_powered
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [7:0] wd1;
  logic [7:0] wd2;
  logic [10:0] fine_tab [8] = '{11'h000, 11'h019, 11'h032, 11'h04B, 11'h055, 11'h06E, 11'h087, 11'h0A0};
  logic [10:0] exp_dly;

  // Write data is delayed twice so it lines up with the decoded outputs.
  always @(posedge sys_clk) begin
    wd1 <= reg_wdata;
    wd2 <= wd1;
  end

  // Expected total delay of output 0 from the delayed write data.
  assign exp_dly = {8'h00, wd2[3:1]} * 11'h0CB + fine_tab[{wd2[0], wd2[6:5]}];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_wr0;
    reg_wr && !reg_rd && reg_addr == 8'h28;
  endsequence
  sequence s_rd0;
    reg_rd && !reg_wr && reg_addr == 8'h28;
  endsequence
  sequence s_pw0;
    reg_wr && !reg_rd && reg_addr == 8'h2C;
  endsequence

  chk_read_valid: assert property (reg_rd |=> reg_rvalid) else $error("read without answer");
  chk_no_spur_valid: assert property (!reg_rd |=> !reg_rvalid) else $error("answer without read");
  chk_write_readback: assert property (s_wr0 ##1 s_rd0 |=> reg_rdata == (wd2 & 8'h7F))
    else $error("read back differs from write");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_delay_sum: assert property (s_wr0 |=> ##1 out_delay_ps[10:0] == exp_dly)
    else $error("delay not coarse plus fine");
  chk_format_power: assert property (s_pw0 |=> ##1 out_powered[0] == !wd2[7] && out_lvpecl[0] == (wd2[4] && !wd2[7]))
    else $error("format or power wrong");
  chk_amp_code: assert property (s_pw0 |=> ##1 out_amp[1:0] == (wd2[7] ? 2'h0 : wd2[3:2]))
    else $error("amplitude code wrong");
  chk_pd_quiet: assert property ((reference_output & ~out_powered) == 8'h00)
    else $error("powered down output active");
  chk_bias_gate: assert property (!bias_type |=> out_bias == 8'h00) else $error("bias without bias type");
endmodule

// ==== core/srocfg_bank.v ====
// Configuration bank for the eight SYSREF-capable reference outputs.
// Assumes a byte register port on sys_clk; clock sources come from pins.
//
// What this block does
// [RULE_01] Source select routes channel clock at 0, SYSREF at 1; resets to 1.
// [RULE_02] Coarse SYSREF delay equals code times 203ps, eight steps.
// [RULE_03] Fine delay codes map to 0,25,50,75,85,110,135,160 ps.
// [RULE_04] Fine delay adds to coarse delay; total is their sum.
// [RULE_05] Bias bit biases output only when global bias-type bit is 1.
// [RULE_06] Software sets bias only for AC-coupled LVDS outputs; the block does not enforce this, bias_on ignores the format bit.
// [RULE_07] Amplitude codes 00..11 select 250, 500, 750, 1000 mV in both formats.
// [RULE_08] Power-down turns the output off; format, enable, amplitude then ignored.
// [RULE_09] Format bit picks LVDS at 0 and LVPECL at 1.
// [RULE_10] Enable at 0 holds output low; at 1 it toggles.
// [RULE_11] Every field exists independently for each of the eight outputs.
// [RULE_12] Fields read back as written and act at once without commit.
`timescale 1ns/10ps
`include "srocfg_defs.vh"

module srocfg_bank #(
  parameter NUM_OUT = 8
) (
  input wire sys_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire bias_type,
  input wire [NUM_OUT-1:0] chan_clk,
  input wire sysref_in,
  output wire [NUM_OUT-1:0] reference_output,
  output wire [NUM_OUT*11-1:0] out_delay_ps,
  output wire [NUM_OUT-1:0] out_bias,
  output wire [NUM_OUT*2-1:0] out_amp,
  output wire [NUM_OUT-1:0] out_lvpecl,
  output wire [NUM_OUT-1:0] out_powered
);

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  // Returns {hit, index}; the power bank shares slots at the delay offset plus step.
  function [3:0] slot_of;
    input [7:0] addr;
    begin
      case (addr & ~`SROC_OFS_PWR_STEP)
        `SROC_OFS_A0: slot_of = 4'h8;
        `SROC_OFS_A1: slot_of = 4'h9;
        `SROC_OFS_A2: slot_of = 4'hA;
        `SROC_OFS_B0: slot_of = 4'hB;
        `SROC_OFS_B1: slot_of = 4'hC;
        `SROC_OFS_C0: slot_of = 4'hD;
        `SROC_OFS_C1: slot_of = 4'hE;
        `SROC_OFS_D: slot_of = 4'hF;
        default: slot_of = 4'h0;
      endcase
    end
  endfunction

  // Enable register bit 7 belongs to output 0, bit 0 to output 7.
  function integer en_bit;
    input integer out_idx;
    begin
      en_bit = NUM_OUT - 1 - out_idx;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Field storage
  // ----------------------------------------------------------------------------
  reg [NUM_OUT-1:0] src_sel;
  reg [NUM_OUT*3-1:0] coarse;
  reg [NUM_OUT*3-1:0] fine;
  reg [NUM_OUT-1:0] bias;
  reg [NUM_OUT*2-1:0] amp;
  reg [NUM_OUT-1:0] pd;
  reg [NUM_OUT-1:0] style;
  reg [7:0] en_reg;
  reg [7:0] next_rdata;
  reg [NUM_OUT-1:0] chan_meta;
  reg [NUM_OUT-1:0] chan_sync;
  reg sysref_meta;
  reg sysref_sync;

  wire [3:0] slot;
  wire [2:0] idx;
  wire pwr_bank;
  wire is_en;
  wire dly_hit;
  wire pwr_hit;
  wire [2:0] wr_fine;
  wire [2:0] wr_coarse;
  wire [1:0] wr_amp;

  // Address decode results: which output, and which of its two registers.
  assign slot = slot_of(reg_addr);
  assign idx = slot[2:0];
  assign pwr_bank = reg_addr[2];
  assign is_en = (reg_addr == `SROC_OFS_ENABLE);
  assign dly_hit = slot[3] & ~pwr_bank;
  assign pwr_hit = slot[3] & pwr_bank;

  // Write data split into the fields that each register kind carries.
  assign wr_fine = {reg_wdata[`SROC_DLY_FINE_HI_BIT], reg_wdata[`SROC_DLY_FINE_LO_MSB:`SROC_DLY_FINE_LO_LSB]};
  assign wr_coarse = reg_wdata[`SROC_DLY_COARSE_MSB:`SROC_DLY_COARSE_LSB];
  assign wr_amp = reg_wdata[`SROC_PWR_AMP_MSB:`SROC_PWR_AMP_LSB];

  // Writes land in the addressed output's own fields and act at once.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      src_sel <= {NUM_OUT{`SROC_RST_MUX}}; // [RULE_01]
      coarse <= {NUM_OUT{`SROC_RST_COARSE}};
      fine <= {NUM_OUT{`SROC_RST_FINE}};
      bias <= {NUM_OUT{`SROC_RST_BIAS}};
      amp <= {NUM_OUT{`SROC_RST_AMP}};
      pd <= {NUM_OUT{`SROC_RST_PD}};
      style <= {NUM_OUT{`SROC_RST_STYLE}};
      en_reg <= {8{`SROC_RST_EN}};
    end else if (reg_wr) begin
      if (dly_hit) begin // [RULE_11] [RULE_12]
        src_sel[idx] <= reg_wdata[`SROC_DLY_MUX_BIT];
        coarse[idx*3 +: 3] <= wr_coarse;
        fine[idx*3 +: 3] <= wr_fine;
      end
      if (pwr_hit) begin // [RULE_11] [RULE_12]
        pd[idx] <= reg_wdata[`SROC_PWR_PD_BIT];
        bias[idx] <= reg_wdata[`SROC_PWR_BIAS_BIT];
        style[idx] <= reg_wdata[`SROC_PWR_STYLE_BIT];
        amp[idx*2 +: 2] <= wr_amp;
      end
      if (is_en) begin
        en_reg <= reg_wdata; // [RULE_12]
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read-data selection
  // ----------------------------------------------------------------------------
  // Packs the addressed fields back into their register slots; unmapped and reserved bits read 0.
  always @* begin
    next_rdata = 8'h00;
    if (dly_hit) begin
      next_rdata[`SROC_DLY_FINE_LO_MSB:`SROC_DLY_FINE_LO_LSB] = fine[idx*3 +: 2];
      next_rdata[`SROC_DLY_MUX_BIT] = src_sel[idx];
      next_rdata[`SROC_DLY_COARSE_MSB:`SROC_DLY_COARSE_LSB] = coarse[idx*3 +: 3];
      next_rdata[`SROC_DLY_FINE_HI_BIT] = fine[idx*3+2];
    end else if (pwr_hit) begin
      next_rdata[`SROC_PWR_PD_BIT] = pd[idx];
      next_rdata[`SROC_PWR_BIAS_BIT] = bias[idx];
      next_rdata[`SROC_PWR_STYLE_BIT] = style[idx];
      next_rdata[`SROC_PWR_AMP_MSB:`SROC_PWR_AMP_LSB] = amp[idx*2 +: 2];
    end else if (is_en) begin
      next_rdata = en_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------------------
  // Read data appear one cycle after the strobe and hold until the next read.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata; // [RULE_12]
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Source synchronisers
  // ----------------------------------------------------------------------------
  // Pin-level clock sources pass two flip-flops before the output logic.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      chan_meta <= {NUM_OUT{1'b0}};
      chan_sync <= {NUM_OUT{1'b0}};
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
    end else begin
      chan_meta <= chan_clk;
      chan_sync <= chan_meta;
      sysref_meta <= sysref_in;
      sysref_sync <= sysref_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // Per-output decode
  // ----------------------------------------------------------------------------
  // One independent decoder for each reference output.
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : gen_out
      srocfg_output u_out ( // [RULE_11]
        .sys_clk(sys_clk),
        .rstn(rstn),
        .src_sel(src_sel[g]),
        .coarse(coarse[g*3 +: 3]),
        .fine(fine[g*3 +: 3]),
        .bias(bias[g]),
        .amp(amp[g*2 +: 2]),
        .pd(pd[g]),
        .style(style[g]),
        .en(en_reg[en_bit(g)]),
        .bias_type(bias_type),
        .chan_clk(chan_sync[g]),
        .sysref(sysref_sync),
        .ref_out(reference_output[g]),
        .delay_ps(out_delay_ps[g*11 +: 11]),
        .bias_on(out_bias[g]),
        .amp_code(out_amp[g*2 +: 2]),
        .lvpecl(out_lvpecl[g]),
        .powered(out_powered[g])
      );
    end
  endgenerate

endmodule

// ==== core/srocfg_defs.vh ====
// Constants for the reference output state configuration bank.
// Assumes byte-wide register access with 8-bit addresses and 8-bit data.
`ifndef SROCFG_DEFS_VH
`define SROCFG_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SROC_OFS_A0 8'h28
`define SROC_OFS_A1 8'h29
`define SROC_OFS_A2 8'h2A
`define SROC_OFS_B0 8'h38
`define SROC_OFS_B1 8'h39
`define SROC_OFS_C0 8'h48
`define SROC_OFS_C1 8'h49
`define SROC_OFS_D 8'h58
`define SROC_OFS_PWR_STEP 8'h04
`define SROC_OFS_ENABLE 8'h76

// ----------------------------------------------------------------------------
// Delay register field positions
// ----------------------------------------------------------------------------
`define SROC_DLY_FINE_LO_MSB 6
`define SROC_DLY_FINE_LO_LSB 5
`define SROC_DLY_MUX_BIT 4
`define SROC_DLY_COARSE_MSB 3
`define SROC_DLY_COARSE_LSB 1
`define SROC_DLY_FINE_HI_BIT 0

// ----------------------------------------------------------------------------
// Power register field positions
// ----------------------------------------------------------------------------
`define SROC_PWR_PD_BIT 7
`define SROC_PWR_BIAS_BIT 5
`define SROC_PWR_STYLE_BIT 4
`define SROC_PWR_AMP_MSB 3
`define SROC_PWR_AMP_LSB 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SROC_RST_MUX 1'h1
`define SROC_RST_COARSE 3'h0
`define SROC_RST_FINE 3'h0
`define SROC_RST_BIAS 1'h0
`define SROC_RST_AMP 2'h0
`define SROC_RST_PD 1'h0
`define SROC_RST_STYLE 1'h0
`define SROC_RST_EN 1'h0

// ----------------------------------------------------------------------------
// Delay figures in picoseconds
// ----------------------------------------------------------------------------
`define SROC_COARSE_STEP_PS 11'h0CB
`define SROC_FINE_PS_0 11'h000
`define SROC_FINE_PS_1 11'h019
`define SROC_FINE_PS_2 11'h032
`define SROC_FINE_PS_3 11'h04B
`define SROC_FINE_PS_4 11'h055
`define SROC_FINE_PS_5 11'h06E
`define SROC_FINE_PS_6 11'h087
`define SROC_FINE_PS_7 11'h0A0

`endif

// ==== core/srocfg_output.v ====
// Per-output decode of one reference output's configuration fields.
// Assumes all inputs are on sys_clk; the clock sources arrive already synchronised.
`timescale 1ns/10ps
`include "srocfg_defs.vh"

module srocfg_output (
  input wire sys_clk,
  input wire rstn,
  input wire src_sel,
  input wire [2:0] coarse,
  input wire [2:0] fine,
  input wire bias,
  input wire [1:0] amp,
  input wire pd,
  input wire style,
  input wire en,
  input wire bias_type,
  input wire chan_clk,
  input wire sysref,
  output reg ref_out,
  output reg [10:0] delay_ps,
  output reg bias_on,
  output reg [1:0] amp_code,
  output reg lvpecl,
  output reg powered
);

  // ----------------------------------------------------------------------------
  // Fine delay lookup
  // ----------------------------------------------------------------------------
  // The fine steps are not uniform, so they come from a table.
  function [10:0] fine_ps;
    input [2:0] code;
    begin
      case (code)
        3'h0: fine_ps = `SROC_FINE_PS_0;
        3'h1: fine_ps = `SROC_FINE_PS_1;
        3'h2: fine_ps = `SROC_FINE_PS_2;
        3'h3: fine_ps = `SROC_FINE_PS_3;
        3'h4: fine_ps = `SROC_FINE_PS_4;
        3'h5: fine_ps = `SROC_FINE_PS_5;
        3'h6: fine_ps = `SROC_FINE_PS_6;
        default: fine_ps = `SROC_FINE_PS_7;
      endcase
    end
  endfunction

  wire [10:0] coarse_ps;
  wire [10:0] next_delay_ps;
  wire next_src;

  // Coarse delay is code times the step; fine delay adds on top.
  assign coarse_ps = `SROC_COARSE_STEP_PS * {8'h00, coarse}; // [RULE_02]
  assign next_delay_ps = coarse_ps + fine_ps(fine); // [RULE_03] [RULE_04]
  // Source select picks SYSREF when set, the channel clock when clear.
  assign next_src = src_sel ? sysref : chan_clk; // [RULE_01]

  // ----------------------------------------------------------------------------
  // Output state
  // ----------------------------------------------------------------------------
  // Power-down overrides format, enable and amplitude; a disabled output sits low.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      ref_out <= 1'b0;
      delay_ps <= 11'h000;
      bias_on <= 1'b0;
      amp_code <= 2'h0;
      lvpecl <= 1'b0;
      powered <= 1'b1;
    end else begin
      ref_out <= ~pd & en & next_src; // [RULE_08] [RULE_10]
      delay_ps <= next_delay_ps;
      bias_on <= bias & bias_type; // [RULE_05]
      amp_code <= pd ? 2'h0 : amp; // [RULE_07] [RULE_08]
      lvpecl <= ~pd & style; // [RULE_09] [RULE_08]
      powered <= ~pd; // [RULE_08]
    end
  end

endmodule
